// >>> hw/can_wake_status_pkg.sv
/*
 * Holds the register offsets, field positions, reset values, fault codes,
 * timing counts and bundled event types for the CAN bus and wake status bank.
 * Assumes a host that reaches the bank over the chip's serial configuration
 * port, decoded upstream into a register address, a read strobe and a clear.
 */
package can_wake_status_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [6:0] ADDR_CAN_BUS_STATUS = 7'h44;  // Bus status
    localparam logic [6:0] ADDR_WAKE_SOURCE_STATUS = 7'h46;  // Wake source
    localparam logic [6:0] ADDR_IO_WAKE_STATUS = 7'h47;  // IO wake source

    // Reset values after power-on or soft reset
    localparam logic [7:0] RST_CAN_BUS_STATUS = 8'h00;
    localparam logic [7:0] RST_WAKE_SOURCE_STATUS = 8'h00;
    localparam logic [7:0] RST_IO_WAKE_STATUS = 8'h00;

    // Implemented bits, all others read zero
    localparam logic [7:0] MASK_CAN_BUS_STATUS = 8'h1F;
    localparam logic [7:0] MASK_WAKE_SOURCE_STATUS = 8'h37;
    localparam logic [7:0] MASK_IO_WAKE_STATUS = 8'h30;

    // Bits kept across restart
    localparam logic [7:0] KEEP_CAN_BUS_STATUS = 8'h1F;
    localparam logic [7:0] KEEP_WAKE_SOURCE_STATUS = 8'h37;
    localparam logic [7:0] KEEP_IO_WAKE_STATUS = 8'h30;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_CAN_TIMEOUT = 4;
    localparam int BIT_SYSTEM_ERROR = 3;
    localparam int BIT_FAULT_LO = 1;
    localparam int BIT_SUPPLY_LOW = 0;
    localparam int BIT_CAN_WAKE = 5;
    localparam int BIT_TIMER_WAKE = 4;
    localparam int BIT_IO2_WAKE = 5;
    localparam int BIT_IO1_WAKE = 4;

    // CAN fault codes
    localparam logic [1:0] FAULT_NONE = 2'h0;
    localparam logic [1:0] FAULT_THERMAL = 2'h1;
    localparam logic [1:0] FAULT_TX_DOM = 2'h2;
    localparam logic [1:0] FAULT_BUS_DOM = 2'h3;

    // Selective-wake error counter limit
    localparam logic [7:0] SWK_ERR_LIMIT = 8'h20;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int TX_ENABLE_TIME_NS = 4000;  // Transmitter enable time
    localparam int TX_ENABLE_CYCLES = (TX_ENABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TXEN_CNT_W = 10;

    ////////////////////////////////////////////////////////////////////////////
    // Transceiver events from the analog side
    typedef struct packed {
        logic thermal_shutdown;           // Transceiver overtemperature
        logic tx_input_dominant_timeout;  // TX input held low too long
        logic bus_dominant_timeout;       // Bus held dominant too long
        logic can_supply_below;           // Comparator: supply below threshold
        logic can_silence_flag;           // Bus silence detected
        logic swk_config_error;           // Selective-wake configuration error
    } can_events_t;

    // Wake events, one bit per source
    typedef struct packed {
        logic can_wake;
        logic timer_wake;
        logic pin3_wake;
        logic pin2_wake;
        logic pin1_wake;
        logic io2_wake;
        logic io1_wake;
    } wake_events_t;

endpackage : can_wake_status_pkg

// >>> hw/can_wake_status.sv
/*
 * CAN bus and wake-source status bank: sticky fault and wake flags, read and
 * clear through a decoded register port, restart retention, CAN timeout
 * interrupt request and transmitter enable gating.
 * Assumes condition inputs and register strobes synchronous to SYS_CLK_I and
 * one-cycle read/clear strobes; the host keeps TX high for the enable time.
 */
`timescale 1ns/1ps

module can_wake_status
    import can_wake_status_pkg::*;
(
    // Clock and resets
    input wire logic SYS_CLK_I,
    input wire logic RST_I,            // Power-on or soft reset
    input wire logic RESTART_I,        // Restart pulse, retains chosen bits
    // Register port
    input wire logic [6:0] REG_ADDR_I,
    input wire logic REG_RD_I,         // Read strobe, data next cycle
    input wire logic REG_CLR_I,        // Clear strobe
    input wire logic [7:0] REG_CLR_MASK_I,  // Ones clear the matching flags
    output logic [7:0] REG_RDATA_O,
    // Mode and configuration
    input wire logic [1:0] CAN_MODE_I,  // Bit0 normal/receive, bit1 selective wake
    input wire logic STOP_OR_NORMAL_I,  // Device in stop or normal mode
    input wire logic CAN_TIMEOUT_IRQ_MASK_I,
    input wire logic TX_INPUT_I,       // Transmit input level, high recessive
    input wire logic BUS_RECESSIVE_I,
    input wire logic [7:0] SWK_ERR_COUNT_I,
    // Events
    input can_events_t CAN_EVENTS_I,
    input wake_events_t WAKE_EVENTS_I,
    input wire logic FAILSAFE_WAKE_I,  // Wake out of fail-safe
    input wire logic INT_FALL_I,       // Interrupt pin falling edge
    // Status outputs
    output logic CAN_TIMEOUT_IRQ_O,    // One-cycle interrupt request
    output logic TX_ENABLE_O,          // Transmitter enabled
    output logic SWK_ENABLE_ALLOWED_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] bus_q, bus_d;          // Bus status
    logic [7:0] wake_q, wake_d;        // Wake source
    logic [7:0] io_q, io_d;            // IO wake
    logic clr_block_q, clr_block_d;    // Timeout clear blocked
    logic fault_act_q, fault_act_d;    // Fault condition still active
    logic [TXEN_CNT_W-1:0] txen_cnt_q, txen_cnt_d;
    logic tx_en_q, tx_en_d;
    logic irq_q, irq_d;
    logic sil_q;                       // Silence flag, previous cycle
    logic [7:0] rdata_q, rdata_d;

    wire logic swk_on = CAN_MODE_I[1];
    wire logic uv_on = CAN_MODE_I[0];
    wire logic uv_now = uv_on & CAN_EVENTS_I.can_supply_below;
    wire logic sil_rise = swk_on & CAN_EVENTS_I.can_silence_flag & ~sil_q;
    wire logic to_set = sil_rise;
    wire logic selwake_system_error_set = swk_on & (CAN_EVENTS_I.swk_config_error | (SWK_ERR_COUNT_I > SWK_ERR_LIMIT));
    wire logic wake_mode = ~CAN_MODE_I[0] | (CAN_MODE_I == 2'h0);

    // Fault code from events, highest code wins
    wire logic [1:0] fault_code = CAN_EVENTS_I.bus_dominant_timeout ? FAULT_BUS_DOM :
                                  CAN_EVENTS_I.tx_input_dominant_timeout ? FAULT_TX_DOM :
                                  CAN_EVENTS_I.thermal_shutdown ? FAULT_THERMAL : FAULT_NONE;

    // Recovery of the active fault
    wire logic rec_tx = TX_INPUT_I | wake_mode;
    wire logic rec_bus = BUS_RECESSIVE_I | wake_mode;
    wire logic rec_th = ~CAN_EVENTS_I.thermal_shutdown;
    wire logic recovered = (bus_q[2:1] == FAULT_TX_DOM) ? rec_tx :
                           (bus_q[2:1] == FAULT_BUS_DOM) ? rec_bus :
                           (bus_q[2:1] == FAULT_THERMAL) ? rec_th : 1'b1;
    wire logic any_fault = (fault_code != FAULT_NONE) | uv_now;

    // Clear masks, timeout bit withheld while blocked
    wire logic [7:0] clr_bus = (REG_CLR_I && REG_ADDR_I == ADDR_CAN_BUS_STATUS) ?
                               (REG_CLR_MASK_I & ~({7'h00, clr_block_q} << BIT_CAN_TIMEOUT)) : 8'h00;
    wire logic [7:0] clr_wake = (REG_CLR_I && REG_ADDR_I == ADDR_WAKE_SOURCE_STATUS) ? REG_CLR_MASK_I : 8'h00;
    wire logic [7:0] clr_io = (REG_CLR_I && REG_ADDR_I == ADDR_IO_WAKE_STATUS) ? REG_CLR_MASK_I : 8'h00;

    // Set vectors
    wire logic [7:0] set_bus = {3'h0, to_set, selwake_system_error_set, fault_code, uv_now};
    wire logic ws = 1'b1;
    wire logic [7:0] set_wake = {2'h0, WAKE_EVENTS_I.can_wake & ws, WAKE_EVENTS_I.timer_wake, 1'b0,
                                 WAKE_EVENTS_I.pin3_wake, WAKE_EVENTS_I.pin2_wake, WAKE_EVENTS_I.pin1_wake};
    wire logic [7:0] set_io = {2'h0, WAKE_EVENTS_I.io2_wake, WAKE_EVENTS_I.io1_wake, 4'h0};

    // Read mux with reserved bits forced low
    wire logic [7:0] rd_mux = (REG_ADDR_I == ADDR_CAN_BUS_STATUS) ? (bus_q & MASK_CAN_BUS_STATUS) :
                              (REG_ADDR_I == ADDR_WAKE_SOURCE_STATUS) ? (wake_q & MASK_WAKE_SOURCE_STATUS) :
                              (REG_ADDR_I == ADDR_IO_WAKE_STATUS) ? (io_q & MASK_IO_WAKE_STATUS) : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        // Sticky flags: set wins over clear
        bus_d = ((bus_q & ~clr_bus) | set_bus) & MASK_CAN_BUS_STATUS;
        // Fault code field is replaced, not ORed, when a new fault arrives
        if (fault_code != FAULT_NONE)
        begin
            bus_d[2:1] = fault_code;
        end
        wake_d = ((wake_q & ~clr_wake) | set_wake) & MASK_WAKE_SOURCE_STATUS;
        io_d = ((io_q & ~clr_io) | set_io) & MASK_IO_WAKE_STATUS;
        // Restart keeps the retained bits only
        if (RESTART_I)
        begin
            bus_d = bus_q & KEEP_CAN_BUS_STATUS;
            wake_d = wake_q & KEEP_WAKE_SOURCE_STATUS;
            io_d = io_q & KEEP_IO_WAKE_STATUS;
        end
        // Clear blocking until the interrupt pin falls
        if (to_set)
        begin
            clr_block_d = 1'b1;
        end
        else if (INT_FALL_I)
        begin
            clr_block_d = 1'b0;
        end
        else
        begin
            clr_block_d = clr_block_q;
        end
        // Fault activity: held until its recovery condition
        if (any_fault)
        begin
            fault_act_d = 1'b1;
        end
        else if (recovered)
        begin
            fault_act_d = 1'b0;
        end
        else
        begin
            fault_act_d = fault_act_q;
        end
        // Transmit enable after TX held high for the enable time
        txen_cnt_d = txen_cnt_q;
        tx_en_d = tx_en_q;
        if (fault_act_q || uv_now || !TX_INPUT_I)
        begin
            txen_cnt_d = '0;
            if (fault_act_q || uv_now)
            begin
                tx_en_d = 1'b0;
            end
        end
        else if (!tx_en_q)
        begin
            if (txen_cnt_q == TXEN_CNT_W'(TX_ENABLE_CYCLES - 1))
            begin
                tx_en_d = 1'b1;
            end
            else
            begin
                txen_cnt_d = txen_cnt_q + 1'b1;
            end
        end
        // Interrupt request on timeout set
        irq_d = to_set & STOP_OR_NORMAL_I & CAN_TIMEOUT_IRQ_MASK_I;
        rdata_d = REG_RD_I ? rd_mux : rdata_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            bus_q <= RST_CAN_BUS_STATUS;
            wake_q <= RST_WAKE_SOURCE_STATUS;
            io_q <= RST_IO_WAKE_STATUS;
            clr_block_q <= 1'b0;
            fault_act_q <= 1'b0;
            txen_cnt_q <= '0;
            tx_en_q <= 1'b0;
            irq_q <= 1'b0;
            sil_q <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            bus_q <= bus_d;
            wake_q <= wake_d;
            io_q <= io_d;
            clr_block_q <= clr_block_d;
            fault_act_q <= fault_act_d;
            txen_cnt_q <= txen_cnt_d;
            tx_en_q <= tx_en_d;
            irq_q <= irq_d;
            sil_q <= CAN_EVENTS_I.can_silence_flag;
            rdata_q <= rdata_d;
        end
    end

    // Outputs from flip-flops, SWK_ENABLE_ALLOWED_O through an inverter
    assign REG_RDATA_O = rdata_q;
    assign CAN_TIMEOUT_IRQ_O = irq_q;
    assign TX_ENABLE_O = tx_en_q;
    assign SWK_ENABLE_ALLOWED_O = ~bus_q[BIT_SYSTEM_ERROR];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_rd_bus;
        REG_RD_I && REG_ADDR_I == ADDR_CAN_BUS_STATUS;
    endsequence

    AST_RESERVED_ZERO: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        s_rd_bus |=> REG_RDATA_O[7:5] == 3'h0)
        else $error("Reserved bits read nonzero");
    AST_TIMEOUT_SET: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (sil_rise && !RESTART_I) |=> bus_q[BIT_CAN_TIMEOUT])
        else $error("Timeout flag not set on silence");
    AST_TIMEOUT_NEEDS_SWK: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (!bus_q[BIT_CAN_TIMEOUT] && !swk_on) |=> !bus_q[BIT_CAN_TIMEOUT])
        else $error("Timeout flag set without selective wake");
    AST_SUPPLY_TX_OFF: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        uv_now |=> !TX_ENABLE_O)
        else $error("Transmitter on during supply low");
    AST_UV_GATED: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (!uv_on && !bus_q[BIT_SUPPLY_LOW] && !RESTART_I) |=> !bus_q[BIT_SUPPLY_LOW])
        else $error("Supply flag set with comparator off");
    AST_IRQ: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (to_set && STOP_OR_NORMAL_I && CAN_TIMEOUT_IRQ_MASK_I) |=> CAN_TIMEOUT_IRQ_O)
        else $error("Missing timeout interrupt");
    AST_CLR_BLOCK: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (clr_block_q && bus_q[BIT_CAN_TIMEOUT] && !RESTART_I) |=> bus_q[BIT_CAN_TIMEOUT])
        else $error("Timeout flag cleared while blocked");
    AST_SET_WINS: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (WAKE_EVENTS_I.can_wake && !RESTART_I) |=> wake_q[BIT_CAN_WAKE])
        else $error("Wake event lost");
    AST_RESTART_KEEP: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        RESTART_I |=> bus_q == $past(bus_q & KEEP_CAN_BUS_STATUS))
        else $error("Restart retention wrong");
    AST_SELWAKE_SYSTEM_ERROR: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (selwake_system_error_set && !RESTART_I) |=> !SWK_ENABLE_ALLOWED_O)
        else $error("System error not flagged");

endmodule : can_wake_status

// >>> tb/host_port_model.sv
/*
 * Host model for the status bank: read and clear cycles, transmit input.
 * Assumes the bank samples its strobes on the rising edge of clk_i.
 */
`timescale 1ns/1ps

module host_port_model (
    // Clock
    input wire logic clk_i,
    // Register port
    output logic [6:0] addr_o,
    output logic rd_o,
    output logic clr_o,
    output logic [7:0] mask_o,
    input wire logic [7:0] rdata_i,
    // Transmit input, high is recessive
    output logic tx_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle port; TX held high so the transmitter may come up
    initial
    begin
        addr_o = 7'h00;
        rd_o = 1'b0;
        clr_o = 1'b0;
        mask_o = 8'h00;
        tx_o = 1'b1;
    end

    // Read: strobe held over one edge, data taken after that edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        d = rdata_i;
    endtask : rd

    // Clear: ones in the mask clear flags at the address
    task automatic clr(input logic [6:0] a, input logic [7:0] m);
        @(posedge clk_i);
        #1;
        addr_o = a;
        mask_o = m;
        clr_o = 1'b1;
        @(posedge clk_i);
        #1;
        clr_o = 1'b0;
    endtask : clr
endmodule : host_port_model

// >>> tb/can_wake_status_tb.sv
/*
 * Self-checking bench for the CAN bus and wake status bank.
 * Assumes the host model drives the register port and the TX input.
 */
`timescale 1ns/1ps

module can_wake_status_tb;
    import can_wake_status_pkg::*;

    localparam logic [6:0] A_BUS = ADDR_CAN_BUS_STATUS;
    localparam logic [6:0] A_WK = ADDR_WAKE_SOURCE_STATUS;
    localparam logic [6:0] A_IO = ADDR_IO_WAKE_STATUS;

    logic clk, rst, restart, rd, clr, son, imask, busrec, fsw, intf, tx;
    logic irq, txen, swk_ok;
    logic [1:0] mode;
    logic [6:0] addr;
    logic [7:0] cmask, rdata, cnt;
    can_events_t ev;
    wake_events_t wk;
    int n_errors = 0;
    int tests_run = 0;
    // Expected wake bit per event index, io1 first
    logic [7:0] wexp [7] = '{8'h10, 8'h20, 8'h01, 8'h02, 8'h04, 8'h10, 8'h20};

    ////////////////////////////////////////////////////////////////////////////
    // Design and host
    can_wake_status i_dut (.SYS_CLK_I(clk), .RST_I(rst), .RESTART_I(restart),
        .REG_ADDR_I(addr), .REG_RD_I(rd), .REG_CLR_I(clr), .REG_CLR_MASK_I(cmask),
        .REG_RDATA_O(rdata), .CAN_MODE_I(mode), .STOP_OR_NORMAL_I(son),
        .CAN_TIMEOUT_IRQ_MASK_I(imask), .TX_INPUT_I(tx), .BUS_RECESSIVE_I(busrec),
        .SWK_ERR_COUNT_I(cnt), .CAN_EVENTS_I(ev), .WAKE_EVENTS_I(wk),
        .FAILSAFE_WAKE_I(fsw), .INT_FALL_I(intf), .CAN_TIMEOUT_IRQ_O(irq),
        .TX_ENABLE_O(txen), .SWK_ENABLE_ALLOWED_O(swk_ok));
    host_port_model i_host (.clk_i(clk), .addr_o(addr), .rd_o(rd), .clr_o(clr),
        .mask_o(cmask), .rdata_i(rdata), .tx_o(tx));

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk(d, e);
    endtask : rchk

    // Move to just after the n-th rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Transmitter comes up some 800 cycles after TX has been high
    task automatic txwait();
        int n;
        n = 0;
        while (txen !== 1'b1 && n < 900)
        begin
            tick(1);
            n++;
        end
        chk({7'h00, n >= 780 && n < 900}, 8'h01);
    endtask : txwait

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // Watchdog, run needs about 1800 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tests
    initial
    begin
        {rst, restart, son, imask, busrec, fsw, intf, mode, cnt} = {7'h54, 2'h0, 8'h00};
        ev = '0;
        wk = '0;
        tick(16);
        rst = 1'b0;
        txwait();
        rchk(A_BUS, 8'h00);
        rchk(A_WK, 8'h00);
        rchk(A_IO, 8'h00);
        rchk(7'h45, 8'h00);
        chk({7'h00, swk_ok}, 8'h01);
        $display("test reset done");
        // Each wake source alone, the CAN one during a fail-safe wake
        for (int i = 0; i < 7; i++)
        begin
            fsw = (i == 6);
            wk = wake_events_t'(7'h01 << i);
            tick(1);
            wk = '0;
            fsw = 1'b0;
            rchk(i < 2 ? A_IO : A_WK, wexp[i]);
            i_host.clr(i < 2 ? A_IO : A_WK, 8'hFF);
        end
        rchk(A_WK, 8'h00);
        // Wake event in the same cycle as a clear
        fork
            i_host.clr(A_WK, 8'hFF);
            begin
                tick(1);
                wk.can_wake = 1'b1;
                tick(1);
                wk = '0;
            end
        join
        rchk(A_WK, 8'h20);
        $display("test wake done");
        // Fault codes thermal, TX dominant, bus dominant
        for (int i = 0; i < 3; i++)
        begin
            ev[5 - i] = 1'b1;
            tick(1);
            ev = '0;
            rchk(A_BUS, {5'h00, 2'(i + 1), 1'b0});
            i_host.clr(A_BUS, 8'hFF);
        end
        rchk(A_BUS, 8'h00);
        // Supply comparator off, then on
        ev.can_supply_below = 1'b1;
        tick(2);
        rchk(A_BUS, 8'h00);
        mode = 2'b01;
        tick(2);
        rchk(A_BUS, 8'h01);
        chk({7'h00, txen}, 8'h00);
        ev.can_supply_below = 1'b0;
        i_host.clr(A_BUS, 8'hFF);
        txwait();
        $display("test fault done");
        // Silence without selective wake
        mode = 2'b00;
        ev.can_silence_flag = 1'b1;
        tick(1);
        ev.can_silence_flag = 1'b0;
        rchk(A_BUS, 8'h00);
        // Silence with selective wake, interrupt masked out
        mode = 2'b10;
        ev.can_silence_flag = 1'b1;
        tick(1);
        chk({7'h00, irq}, 8'h00);
        ev.can_silence_flag = 1'b0;
        rchk(A_BUS, 8'h10);
        intf = 1'b1;
        tick(1);
        intf = 1'b0;
        i_host.clr(A_BUS, 8'h10);
        rchk(A_BUS, 8'h00);
        // Interrupt allowed: one-cycle pulse, clear held off
        imask = 1'b1;
        ev.can_silence_flag = 1'b1;
        tick(1);
        chk({7'h00, irq}, 8'h01);
        tick(1);
        chk({7'h00, irq}, 8'h00);
        ev.can_silence_flag = 1'b0;
        i_host.clr(A_BUS, 8'h10);
        rchk(A_BUS, 8'h10);
        intf = 1'b1;
        tick(1);
        intf = 1'b0;
        i_host.clr(A_BUS, 8'h10);
        rchk(A_BUS, 8'h00);
        $display("test timeout done");
        // Error counter limit, selective wake off then on
        mode = 2'b00;
        cnt = 8'h21;
        tick(2);
        rchk(A_BUS, 8'h00);
        mode = 2'b10;
        cnt = 8'h20;
        tick(2);
        rchk(A_BUS, 8'h00);
        cnt = 8'h21;
        tick(2);
        rchk(A_BUS, 8'h08);
        chk({7'h00, swk_ok}, 8'h00);
        cnt = 8'h00;
        i_host.clr(A_BUS, 8'h08);
        rchk(A_BUS, 8'h00);
        $display("test error done");
        // Fill everything, restart keeps, reset clears
        mode = 2'b11;
        ev = 6'h27;
        wk = 7'h7F;
        tick(1);
        ev = '0;
        wk = '0;
        restart = 1'b1;
        tick(1);
        restart = 1'b0;
        rchk(A_BUS, 8'h1B);
        rchk(A_WK, 8'h37);
        rchk(A_IO, 8'h30);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        rchk(A_BUS, 8'h00);
        rchk(A_WK, 8'h00);
        $display("test restart done");
        stop_test();
    end
endmodule : can_wake_status_tb
